// file: pkg/clh_pkg.sv
// What this block does
// [R1] Register select picks data or instruction side
// [R2] Read/write line high reads, low writes
// [R3] Drive reads while strobe high; capture on fall
// [R4] Wide bus: lines 0-3 low, 4-7 high
// [R5] Narrow bus uses only lines 4 to 7
// [R6] Narrow bus: high nibble first, then low
// [R7] Instruction register is write only
// [R8] Data writes copied into selected memory
// [R9] Address set prefetches byte into data holding
// [R10] Data read prefetches next address
// [R11] Instruction write stores instruction byte
// [R12] Status read returns busy and address counter
// [R13] Data write loads data holding register
// [R14] Data read returns data holding register
// [R15] Busy is one; instructions refused meanwhile
// [R16] Host waits for busy zero before instructing
// [R17] Address instruction loads address counter
// [R18] Address instruction selects text or glyph memory
// [R19] Counter steps by one after each access
// [R20] Direction bit set counts up, clear down
// [R21] Text memory holds 80 bytes
// [R22] Busy until internal transfer ends; status free
`default_nettype none

package clh_pkg;

    // ------------------------------------------------------------
    // Widths and memory sizes
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int AC_W = 7;
    localparam int TEXT_DEPTH = 80;
    localparam int GLYPH_DEPTH = 64;
    localparam int GLYPH_AW = 6;
    localparam logic [6:0] TEXT_LAST = 7'h4f;

    // ------------------------------------------------------------
    // Instruction byte fields
    // ------------------------------------------------------------
    localparam int OP_TEXT_ADDR_BIT = 7;
    localparam int OP_GLYPH_ADDR_BIT = 6;
    localparam int OP_FUNC_BIT = 5;
    localparam int OP_WIDE_BIT = 4;
    localparam int OP_ENTRY_BIT = 2;
    localparam int OP_DIR_BIT = 1;

    // ------------------------------------------------------------
    // Reset values and drive patterns
    // ------------------------------------------------------------
    localparam logic [6:0] AC_RST = 7'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic DIR_RST = 1'b1;
    localparam logic WIDE_RST = 1'b1;
    localparam logic [7:0] OE_FULL = 8'hff;
    localparam logic [7:0] OE_HIGH = 8'hf0;
    localparam logic [7:0] OE_NONE = 8'h00;
    localparam logic [3:0] NIB_ZERO = 4'h0;

    // ------------------------------------------------------------
    // Timing: plain instruction execution time
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int EXEC_NS = 40;
    localparam int EXEC_CYCLES_I =
        (EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] EXEC_CYCLES = 8'(EXEC_CYCLES_I);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Host pins as sampled
    typedef struct packed {
        logic register_select;
        logic read_not_write;
        logic strobe;
        logic [7:0] data;
    } clh_pins_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WRITE,
        ST_FETCH,
        ST_LOAD,
        ST_EXEC
    } clh_state_t;

    // ------------------------------------------------------------
    // Address counter step, wraps inside the selected memory
    // ------------------------------------------------------------
    function automatic logic [6:0] clh_step(input logic [6:0] a,
                                            input logic up,
                                            input logic glyph);
        logic [5:0] g;
        g = up ? a[5:0] + 6'h01 : a[5:0] - 6'h01;
        if (glyph)
        begin
            return {1'b0, g};
        end
        else if (up)
        begin
            return (a >= TEXT_LAST) ? AC_RST : a + 7'h01;
        end
        else
        begin
            return (a == AC_RST) ? TEXT_LAST : a - 7'h01;
        end
    endfunction

endpackage

`default_nettype wire

// file: hdl/clh_mem.sv
`default_nettype none

// ----------------------------------------------------------------
// Single port memory with registered read data
// ----------------------------------------------------------------
module clh_mem
    import clh_pkg::*;
#(
    parameter int DEPTH = TEXT_DEPTH,
    parameter int AW = AC_W
)
(
    input wire logic clk_in,
    input wire logic write_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    output logic [DATA_W-1:0] rdata_out
);

    // Refuse a depth that the address cannot reach
    if (DEPTH > (1 << AW))
    begin : g_bad_depth
        $error("clh_mem depth exceeds address range");
    end

    logic [DATA_W-1:0] mem_r [DEPTH];   // Storage, no reset needed
    logic [DATA_W-1:0] rdata_nxt;       // Next read word
    logic in_range;                     // Address inside storage

    // Out of range reads give zero, writes are dropped
    always_comb
    begin
        in_range = 32'(addr_in) < DEPTH;
        rdata_nxt = in_range ? mem_r[addr_in] : BYTE_RST;
    end

    // Storage write and read register
    always_ff @(posedge clk_in)
    begin
        if (write_in && in_range)
        begin
            mem_r[addr_in] <= wdata_in;
        end
        rdata_out <= rdata_nxt;
    end

endmodule

`default_nettype wire

// file: hdl/clh_host_port.sv
`default_nettype none

// ----------------------------------------------------------------
// Strobe driven host port with prefetching data holding register
// ----------------------------------------------------------------
module clh_host_port
    import clh_pkg::*;
#(
    parameter int TEXT_DEPTH_P = TEXT_DEPTH
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire clh_pins_t pins_in,
    output logic [DATA_W-1:0] data_out,
    output logic [DATA_W-1:0] data_oe_out,
    output logic busy_out
);

    // Text memory must fit the address counter
    if (TEXT_DEPTH_P > (1 << AC_W) || TEXT_DEPTH_P != TEXT_DEPTH)
    begin : g_bad_depth
        $error("clh_host_port text depth not supported");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    clh_pins_t sync1_r;          // First stage, read only by second
    clh_pins_t sync2_r;          // Safe copy of the pins
    logic strobe_prev_r;         // Strobe one cycle back
    logic strobe_fall;           // Strobe high-to-low seen

    // Two flops before any logic looks at the pins
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            strobe_prev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
            strobe_prev_r <= sync2_r.strobe;
        end
    end

    assign strobe_fall = strobe_prev_r && !sync2_r.strobe; // see [R3]

    // ------------------------------------------------------------
    // Byte assembly
    // ------------------------------------------------------------
    logic low_phase_r, low_phase_nxt;   // Waiting for low nibble
    logic [3:0] hi_nib_r, hi_nib_nxt;   // Held high nibble
    logic byte_done;                    // Whole byte moved
    logic [7:0] host_byte;              // Assembled write byte
    logic wide_r;                       // Eight bit bus selected

    // Count strobes into bytes for both bus widths
    always_comb
    begin
        low_phase_nxt = low_phase_r;
        hi_nib_nxt = hi_nib_r;
        byte_done = 1'b0;
        host_byte = sync2_r.data;           // see [R4]
        if (strobe_fall)
        begin
            if (wide_r)
            begin
                byte_done = 1'b1;
            end
            else if (!low_phase_r)
            begin
                // High nibble comes first on lines 4 to 7
                low_phase_nxt = 1'b1;       // see [R6]
                hi_nib_nxt = sync2_r.data[7:4]; // see [R5]
            end
            else
            begin
                low_phase_nxt = 1'b0;
                byte_done = 1'b1;
                host_byte = {hi_nib_r, sync2_r.data[7:4]}; // see [R6]
            end
        end
    end

    // Nibble state registers
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            low_phase_r <= 1'b0;
            hi_nib_r <= NIB_ZERO;
        end
        else
        begin
            low_phase_r <= low_phase_nxt;
            hi_nib_r <= hi_nib_nxt;
        end
    end

    // ------------------------------------------------------------
    // Sequencer and registers
    // ------------------------------------------------------------
    clh_state_t state_r, state_nxt;     // Internal operation
    logic [6:0] ac_r, ac_nxt;           // Address counter
    logic glyph_r, glyph_nxt;           // Glyph memory selected
    logic dir_r, dir_nxt;               // Count up when set
    logic wide_nxt;                     // Next bus width
    logic [7:0] instr_r, instr_nxt;     // Instruction register
    logic [7:0] hold_r, hold_nxt;       // Data holding register
    logic [7:0] cnt_r, cnt_nxt;         // Execution countdown
    logic busy_r, busy_nxt;             // Busy flag
    logic [7:0] text_rdata;             // Text memory word
    logic [7:0] glyph_rdata;            // Glyph memory word
    logic mem_write;                    // Memory write strobe
    logic is_write;                     // Host byte was a write

    assign is_write = !sync2_r.read_not_write; // see [R2]

    // Next state of every register of the sequencer
    always_comb
    begin
        state_nxt = state_r;
        ac_nxt = ac_r;
        glyph_nxt = glyph_r;
        dir_nxt = dir_r;
        wide_nxt = wide_r;
        instr_nxt = instr_r;
        hold_nxt = hold_r;
        cnt_nxt = cnt_r;
        mem_write = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                // Bytes arriving while busy are dropped: see [R15]
                if (byte_done && is_write && !sync2_r.register_select)
                begin
                    instr_nxt = host_byte;              // see [R11]
                    state_nxt = ST_EXEC;
                    cnt_nxt = EXEC_CYCLES - 8'h01;
                    if (host_byte[OP_TEXT_ADDR_BIT])
                    begin
                        ac_nxt = host_byte[6:0];        // see [R17]
                        glyph_nxt = 1'b0;               // see [R18]
                        state_nxt = ST_FETCH;           // see [R9]
                    end
                    else if (host_byte[OP_GLYPH_ADDR_BIT])
                    begin
                        ac_nxt = {1'b0, host_byte[5:0]}; // see [R17]
                        glyph_nxt = 1'b1;               // see [R18]
                        state_nxt = ST_FETCH;           // see [R9]
                    end
                    else if (host_byte[OP_FUNC_BIT])
                    begin
                        wide_nxt = host_byte[OP_WIDE_BIT];
                    end
                    else if (host_byte[OP_ENTRY_BIT])
                    begin
                        dir_nxt = host_byte[OP_DIR_BIT]; // see [R20]
                    end
                end
                else if (byte_done && is_write)
                begin
                    hold_nxt = host_byte;               // see [R13]
                    state_nxt = ST_WRITE;               // see [R8]
                end
                else if (byte_done && sync2_r.register_select)
                begin
                    // Host has taken the byte; fetch the next one
                    ac_nxt = clh_step(ac_r, dir_r, glyph_r); // see [R19]
                    state_nxt = ST_FETCH;               // see [R10]
                end
            end
            ST_WRITE:
            begin
                mem_write = 1'b1;                       // see [R8]
                ac_nxt = clh_step(ac_r, dir_r, glyph_r); // see [R19]
                state_nxt = ST_IDLE;
            end
            ST_FETCH:
            begin
                state_nxt = ST_LOAD;
            end
            ST_LOAD:
            begin
                hold_nxt = glyph_r ? glyph_rdata : text_rdata; // see [R9]
                state_nxt = ST_IDLE;
            end
            ST_EXEC:
            begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == BYTE_RST)
                begin
                    state_nxt = ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
        busy_nxt = state_nxt != ST_IDLE;                // see [R22]
    end

    // Sequencer registers
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_r <= ST_IDLE;
            ac_r <= AC_RST;
            glyph_r <= 1'b0;
            dir_r <= DIR_RST;
            wide_r <= WIDE_RST;
            instr_r <= BYTE_RST;
            hold_r <= BYTE_RST;
            cnt_r <= BYTE_RST;
            busy_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            ac_r <= ac_nxt;
            glyph_r <= glyph_nxt;
            dir_r <= dir_nxt;
            wide_r <= wide_nxt;
            instr_r <= instr_nxt;
            hold_r <= hold_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ------------------------------------------------------------
    // Memories; reads are issued in fetch and land in load
    // ------------------------------------------------------------
    clh_mem #(.DEPTH(TEXT_DEPTH_P), .AW(AC_W)) u_text_mem ( // see [R21]
        .clk_in(clk_in),
        .write_in(mem_write && !glyph_r),
        .addr_in(ac_r),
        .wdata_in(hold_r),
        .rdata_out(text_rdata)
    );

    clh_mem #(.DEPTH(GLYPH_DEPTH), .AW(GLYPH_AW)) u_glyph_mem (
        .clk_in(clk_in),
        .write_in(mem_write && glyph_r),
        .addr_in(ac_r[5:0]),
        .wdata_in(hold_r),
        .rdata_out(glyph_rdata)
    );

    // ------------------------------------------------------------
    // Read drive
    // ------------------------------------------------------------
    logic [7:0] rd_byte;                // Byte the host reads
    logic [7:0] dout_nxt, oe_nxt;       // Next pin drive

    // Drive only while strobe high on a read; instruction register
    // never reaches the pins, status is never held off
    always_comb
    begin
        rd_byte = sync2_r.register_select ? hold_r   // see [R1] [R14]
                                          : {busy_r, ac_r}; // see [R7] [R12]
        dout_nxt = BYTE_RST;
        oe_nxt = OE_NONE;
        if (sync2_r.strobe && sync2_r.read_not_write) // see [R3]
        begin
            if (wide_r)
            begin
                dout_nxt = rd_byte;
                oe_nxt = OE_FULL;
            end
            else
            begin
                dout_nxt = low_phase_r ? {rd_byte[3:0], NIB_ZERO}
                                       : {rd_byte[7:4], NIB_ZERO};
                oe_nxt = OE_HIGH;                       // see [R5]
            end
        end
    end

    // Output registers
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            data_out <= BYTE_RST;
            data_oe_out <= OE_NONE;
        end
        else
        begin
            data_out <= dout_nxt;
            data_oe_out <= oe_nxt;
        end
    end

    assign busy_out = busy_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    logic instr_take;                   // Accepted instruction byte
    assign instr_take = state_r == ST_IDLE && byte_done && is_write
                        && !sync2_r.register_select;

    property p_drive_read;
        (data_oe_out != OE_NONE)
            |-> $past(sync2_r.strobe && sync2_r.read_not_write);
    endproperty
    a_drive_read: assert property (p_drive_read) // see [R3]
        else $error("pins driven outside a read strobe");

    property p_status;
        (data_oe_out == OE_FULL && !$past(sync2_r.register_select))
            |-> data_out == {$past(busy_r), $past(ac_r)};
    endproperty
    a_status: assert property (p_status) // see [R12]
        else $error("status byte wrong");

    property p_data_read;
        (data_oe_out == OE_FULL && $past(sync2_r.register_select))
            |-> data_out == $past(hold_r);
    endproperty
    a_data_read: assert property (p_data_read) // see [R14]
        else $error("data read not from holding register");

    property p_narrow;
        (data_oe_out != OE_NONE && !$past(wide_r))
            |-> data_oe_out == OE_HIGH;
    endproperty
    a_narrow: assert property (p_narrow) // see [R5]
        else $error("narrow bus drove low lines");

    property p_busy_refuse;
        (busy_r && byte_done && is_write) |=> $stable(instr_r);
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) // see [R15]
        else $error("instruction taken while busy");

    property p_set_addr;
        (instr_take && host_byte[OP_TEXT_ADDR_BIT])
            |=> ac_r == $past(host_byte[6:0]) && !glyph_r ##2 !busy_r;
    endproperty
    a_set_addr: assert property (p_set_addr) // see [R17]
        else $error("address set did not load counter");

    property p_step;
        (state_r == ST_WRITE)
            |=> ac_r == clh_step($past(ac_r), $past(dir_r), $past(glyph_r));
    endproperty
    a_step: assert property (p_step) // see [R19]
        else $error("counter did not step after write");

    property p_prefetch;
        (state_r == ST_FETCH) |=> (state_r == ST_LOAD)
            ##1 hold_r == $past(glyph_r ? glyph_rdata : text_rdata);
    endproperty
    a_prefetch: assert property (p_prefetch) // see [R10]
        else $error("prefetch did not load holding register");

    property p_busy_write;
        (state_r == ST_IDLE && byte_done && is_write) |=> busy_r;
    endproperty
    a_busy_write: assert property (p_busy_write) // see [R22]
        else $error("busy not raised after accepted write");

    c_instr: cover property (instr_take);
    c_data_write: cover property (state_r == ST_WRITE);
    c_narrow_byte: cover property (!wide_r && byte_done);
    c_prefetch: cover property (state_r == ST_LOAD ##1 !busy_r);

endmodule

`default_nettype wire

// file: sim/clh_tb_host.sv
`default_nettype none

// ------------------------------------------------------------
// Host processor model on the strobe bus
// ------------------------------------------------------------
module clh_tb_host
    import clh_pkg::*;
(
    input wire logic clk_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic [DATA_W-1:0] data_oe_in,
    output var clh_pins_t pins_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic rs = 1'b0; // Register select
    logic rw = 1'b1; // High reads
    logic stb = 1'b0; // Strobe
    logic wide = WIDE_RST; // Host view of bus width
    logic [7:0] hd = 8'h00; // Host drive value
    logic [7:0] keep = 8'h00; // Lines the host drives
    logic [7:0] junk = 8'h5a; // Released lines, no pull
    logic [7:0] oe_seen = 8'h00; // Enables at last sample

    // Floating lines move every cycle, never a stale value
    always @(negedge clk_in)
    begin
        junk <= ~junk;
    end

    // Wire level from both parties' enables
    always_comb
    begin
        pins_out.register_select = rs;
        pins_out.read_not_write = rw;
        pins_out.strobe = stb;
        for (int i = 0; i < 8; i++)
        begin
            pins_out.data[i] = data_oe_in[i] ? data_in[i]
                             : (keep[i] ? hd[i] : junk[i]);
        end
    end

    // One strobe; selects and data held well past the fall
    task automatic cycle(input logic rs_v, input logic rw_v,
                         input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_in);
        rs = rs_v;
        rw = rw_v;
        hd = d;
        keep = rw_v ? OE_NONE : (wide ? OE_FULL : OE_HIGH);
        repeat (2) @(negedge clk_in);
        stb = 1'b1;
        repeat (4) @(negedge clk_in);
        q = pins_out.data;
        oe_seen = data_oe_in;
        stb = 1'b0;
        // Three cycles of hold keeps back-to-back strobes tight enough
        // to land a byte inside a long instruction
        repeat (3) @(negedge clk_in);
        keep = OE_NONE;
    endtask

    // One byte; narrow bus splits it high nibble first
    task automatic xfer(input logic rs_v, input logic rw_v,
                        input logic [7:0] d, output logic [7:0] q);
        logic [7:0] h;
        logic [7:0] l;
        if (wide)
        begin
            cycle(rs_v, rw_v, d, q);
        end
        else
        begin
            cycle(rs_v, rw_v, {d[7:4], NIB_ZERO}, h);
            cycle(rs_v, rw_v, {d[3:0], NIB_ZERO}, l);
            q = {h[7:4], l[7:4]};
        end
        // A function set changes width only once fully sent
        if (!rs_v && !rw_v && d[7:5] == 3'b001)
        begin
            wide = d[OP_WIDE_BIT];
        end
    endtask

    // Poll status until idle; bounded so a stuck flag shows
    task automatic wait_idle(output logic [7:0] s);
        int n;
        n = 0;
        xfer(1'b0, 1'b1, 8'h00, s);
        while (s[7] !== 1'b0 && n < 40)
        begin
            xfer(1'b0, 1'b1, 8'h00, s);
            n++;
        end
    endtask

endmodule

`default_nettype wire

// file: sim/testbench.sv
`default_nettype none

// ------------------------------------------------------------
// Self-checking bench for the host port
// ------------------------------------------------------------
module testbench
    import clh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    clh_pins_t pins; // Resolved host pins
    logic [7:0] dout;
    logic [7:0] doe;
    logic busy;
    int n_fail = 0;
    int tests_run = 0;
    int seed = 96400; // Fixed so runs repeat
    logic [7:0] q;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [6:0] a;

    // 250 MHz clock
    initial
    begin
        forever #2 clk_in = ~clk_in;
    end

    clh_host_port dut (.clk_in(clk_in), .reset_in(reset_in),
        .pins_in(pins), .data_out(dout), .data_oe_out(doe),
        .busy_out(busy));
    clh_tb_host host (.clk_in(clk_in), .data_in(dout),
        .data_oe_in(doe), .pins_out(pins));

    // Compare and count
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Verdict and stop
    task automatic end_of_test();
        if (n_fail == 0 && tests_run > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Expected counter step inside the 80-byte text memory
    function automatic logic [6:0] nxt(input logic [6:0] x,
                                       input logic up);
        if (up)
        begin
            return (x == 7'h4f) ? 7'h00 : x + 7'h01;
        end
        return (x == 7'h00) ? 7'h4f : x - 7'h01;
    endfunction

    // Bus operations, each followed by the idle poll
    task automatic ctl(input logic [7:0] d);
        logic [7:0] s;
        host.xfer(1'b0, 1'b0, d, s);
        host.wait_idle(s);
        check("idle after instruction", {7'h00, s[7]}, 8'h00);
    endtask

    task automatic wr(input logic [7:0] d);
        logic [7:0] s;
        host.xfer(1'b1, 1'b0, d, s);
        host.wait_idle(s);
        check("idle after write", {7'h00, s[7]}, 8'h00);
    endtask

    task automatic rd(output logic [7:0] d);
        logic [7:0] s;
        host.xfer(1'b1, 1'b1, 8'h00, d);
        host.wait_idle(s);
        check("idle after read", {7'h00, s[7]}, 8'h00);
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(negedge clk_in);
        reset_in = 1'b0;
        check("busy at reset", {7'h00, busy}, 8'h00);
        check("enables at reset", doe, OE_NONE);
        b0 = 8'($random(seed));
        b1 = 8'($random(seed));
        b2 = 8'($random(seed));
        // Writes across the top of text memory
        ctl(8'h06);
        ctl(8'hce);
        host.wait_idle(q);
        check("counter set", q, 8'h4e);
        wr(b0);
        wr(b1);
        wr(b2);
        host.wait_idle(q);
        check("count up", q, {1'b0, nxt(nxt(7'h4f, 1), 1)});
        ctl(8'hce);
        rd(q);
        check("prefetch", q, b0);
        rd(q);
        check("next read", q, b1);
        rd(q);
        check("wrapped read", q, b2);
        // Count down below zero
        ctl(8'h04);
        ctl(8'h81);
        wr(b2);
        wr(b0);
        host.wait_idle(q);
        check("count down", q, {1'b0, nxt(7'h00, 1'b0)});
        ctl(8'h06);
        // Glyph memory is separate and wraps in six bits
        ctl(8'h7f);
        wr(b1);
        wr(b2);
        host.wait_idle(q);
        check("glyph wrap", q, 8'h01);
        ctl(8'h7f);
        rd(q);
        check("glyph read", q, b1);
        ctl(8'hcf);
        rd(q);
        check("text kept", q, b1);
        // Status straight after a long instruction
        ctl(8'h80);
        host.xfer(1'b0, 1'b0, 8'h01, q);
        host.xfer(1'b0, 1'b1, 8'h00, q);
        check("busy status", q, 8'h80);
        host.wait_idle(q);
        // A write landing inside a long instruction must be dropped
        host.xfer(1'b0, 1'b0, 8'h01, q);
        host.xfer(1'b1, 1'b0, ~b0, q);
        host.wait_idle(q);
        check("write refused", q, 8'h00);
        // Narrow bus, then back to wide
        ctl(8'h20);
        ctl(8'h90);
        wr(b0);
        ctl(8'h90);
        rd(q);
        check("narrow read", q, b0);
        check("narrow enables", host.oe_seen, OE_HIGH);
        host.wait_idle(q);
        check("narrow status", q, 8'h11);
        ctl(8'h30);
        ctl(8'h90);
        rd(q);
        check("wide read", q, b0);
        check("wide enables", host.oe_seen, OE_FULL);
        // Random places in text memory
        repeat (8)
        begin
            a = 7'($unsigned($random(seed)) % 80);
            b0 = 8'($random(seed));
            ctl({1'b1, a});
            wr(b0);
            ctl({1'b1, a});
            rd(q);
            check("random byte", q, b0);
        end
        end_of_test();
    end

    // Hang guard, well past the expected run length
    initial
    begin
        repeat (30000) @(posedge clk_in);
        n_fail++;
        end_of_test();
    end

endmodule

`default_nettype wire
